//--- src/glt_tunnel.sv
`timescale 1ns/1ns
`include "glt_defs.svh"
module glt_tunnel #(
  parameter int PINS = 13,
  parameter int LAT_MAX = `GLT_LAT_CYC
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Pins
  input wire logic [PINS-1:0] pin_in_in,
  output logic [PINS-1:0] pin_out_out,
  output logic [PINS-1:0] pin_oe_out,
  // Link send side
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output glt_pkg::glt_tag_t tx_tag_out,
  output logic tx_level_out,
  output glt_pkg::glt_stamp_t tx_stamp_out,
  output logic tx_comp_out,
  output logic tx_last_out,
  output logic [6:0] tx_cost_out,
  // Link receive side
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire glt_pkg::glt_tag_t rx_tag_in,
  input wire logic rx_level_in,
  input wire glt_pkg::glt_stamp_t rx_stamp_in,
  input wire logic rx_comp_in
);

  if (PINS < 1 || PINS > 13) begin : g_bad_pins
    $error("PINS must be 1 to 13");
  end
  if (LAT_MAX < 1 || LAT_MAX > 32767) begin : g_bad_lat
    $error("LAT_MAX out of range");
  end

  typedef struct packed {
    glt_pkg::glt_tx_e tx_st;
    logic [PINS-1:0] s1;
    logic [PINS-1:0] s2;
    logic [PINS-1:0] s3;
    logic [PINS-1:0] stab;
    logic [PINS-1:0] tx_en;
    logic [PINS-1:0] rx_en;
    logic [PINS-1:0] sw_oe;
    logic [PINS-1:0] od;
    logic [PINS-1:0] lvl;
    logic [PINS-1:0] prio;
    logic [PINS-1:0] pend;
    logic [PINS-1:0] plvl;
    logic [PINS-1:0] echo;
    logic [PINS-1:0] hpend;
    logic [PINS-1:0] hlvl;
    logic [PINS-1:0][4:0] tx_id;
    logic [PINS-1:0][4:0] rx_id;
    logic [PINS-1:0][15:0] pseq;
    logic [PINS-1:0][15:0] hts;
    logic [15:0] now;
    logic [15:0] dly;
    logic comp;
    logic [31:0] rdata;
    logic [4:0] o_tag;
    logic o_lvl;
    logic [15:0] o_stamp;
    logic o_comp;
    logic o_last;
  } glt_state_s;

  glt_state_s st_r;
  glt_state_s st_nxt;

  function automatic logic [15:0] age(input logic [15:0] now, input logic [15:0] t);
    age = now - t;
  endfunction

  function automatic logic cfg_hit(input logic [7:0] a);
    cfg_hit = (a[7:6] == 2'b00) && (a[1:0] == 2'b00) && (int'(a[5:2]) < PINS);
  endfunction

  // Selection of the next transition to send
  logic any_pend;
  logic starve;
  logic [PINS-1:0] drv_en;
  logic [PINS-1:0] drv_v;
  logic [PINS-1:0] rx_match;
  logic [PINS-1:0] due;
  logic [PINS-1:0] swallow;
  int best;
  always_comb begin
    any_pend = |st_r.pend;
    starve = 1'b0;
    best = 0;
    for (int i = 0; i < PINS; i++) begin
      if (st_r.pend[i] && age(st_r.now, st_r.pseq[i]) >= 16'(LAT_MAX)) begin
        starve = 1'b1;
      end
    end
    for (int i = 0; i < PINS; i++) begin
      if (st_r.pend[i]) begin
        if (!st_r.pend[best]) begin
          best = i;
        end else if ((st_r.prio[i] && !starve) && !(st_r.prio[best] && !starve)) begin
          best = i;
        end else if (((st_r.prio[i] && !starve) == (st_r.prio[best] && !starve)) &&
                     age(st_r.now, st_r.pseq[i]) > age(st_r.now, st_r.pseq[best])) begin
          best = i;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      rx_match[i] = st_r.rx_en[i] && (st_r.rx_id[i] == rx_tag_in);
      swallow[i] = st_r.echo[i] && st_r.s2[i] == st_r.s3[i] && st_r.s3[i] != st_r.stab[i] &&
                   st_r.s3[i] == st_r.lvl[i];
    end
    rx_ready_out = ~|(rx_match & st_r.hpend);
  end

  // release held transitions, or drive plain ones at once
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      drv_en[i] = 1'b0;
      drv_v[i] = 1'b0;
      due[i] = st_r.hpend[i] && age(st_r.now, st_r.hts[i]) >= st_r.dly;
      if (due[i]) begin
        drv_en[i] = 1'b1;
        drv_v[i] = st_r.hlvl[i];
      end else if (rx_valid_in && rx_ready_out && rx_match[i] && !rx_comp_in) begin
        drv_en[i] = 1'b1;
        drv_v[i] = rx_level_in;
      end
    end
  end

  always_comb begin
    int k;
    k = 0;
    st_nxt = st_r;
    st_nxt.s1 = pin_in_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.now = st_r.now + 16'h0001;
    st_nxt.rdata = 32'h0000_0000;
    if (reg_wr_in) begin
      if (cfg_hit(reg_addr_in)) begin
        k = int'(reg_addr_in[5:2]);
        st_nxt.tx_en[k] = reg_wdata_in[`GLT_F_TX_EN];
        st_nxt.rx_en[k] = reg_wdata_in[`GLT_F_RX_EN];
        st_nxt.sw_oe[k] = reg_wdata_in[`GLT_F_SW_OE];
        st_nxt.od[k] = reg_wdata_in[`GLT_F_OD];
        st_nxt.lvl[k] = reg_wdata_in[`GLT_F_LVL];
        st_nxt.prio[k] = reg_wdata_in[`GLT_F_PRIO];
        st_nxt.tx_id[k] = reg_wdata_in[`GLT_F_TX_ID +: 5];
        st_nxt.rx_id[k] = reg_wdata_in[`GLT_F_RX_ID +: 5];
      end else if (reg_addr_in == `GLT_CTRL) begin
        st_nxt.comp = reg_wdata_in[`GLT_F_COMP];
      end else if (reg_addr_in == `GLT_DELAY) begin
        st_nxt.dly = reg_wdata_in[15:0];
      end
    end
    if (reg_rd_in) begin
      if (cfg_hit(reg_addr_in)) begin
        k = int'(reg_addr_in[5:2]);
        st_nxt.rdata[`GLT_F_TX_EN] = st_r.tx_en[k];
        st_nxt.rdata[`GLT_F_RX_EN] = st_r.rx_en[k];
        st_nxt.rdata[`GLT_F_SW_OE] = st_r.sw_oe[k];
        st_nxt.rdata[`GLT_F_OD] = st_r.od[k];
        st_nxt.rdata[`GLT_F_LVL] = st_r.lvl[k];
        st_nxt.rdata[`GLT_F_PRIO] = st_r.prio[k];
        st_nxt.rdata[`GLT_F_IN] = st_r.stab[k];
        st_nxt.rdata[`GLT_F_TX_ID +: 5] = st_r.tx_id[k];
        st_nxt.rdata[`GLT_F_RX_ID +: 5] = st_r.rx_id[k];
      end else if (reg_addr_in == `GLT_CTRL) begin
        st_nxt.rdata[`GLT_F_COMP] = st_r.comp;
      end else if (reg_addr_in == `GLT_DELAY) begin
        st_nxt.rdata[15:0] = st_r.dly;
      end else if (reg_addr_in == `GLT_LEVELS) begin
        st_nxt.rdata[PINS-1:0] = st_r.stab;
      end else if (reg_addr_in == `GLT_PENDING) begin
        st_nxt.rdata[PINS-1:0] = st_r.pend;
      end
    end
    case (st_r.tx_st)
      glt_pkg::GLT_TX_IDLE: begin
        if (any_pend) begin
          st_nxt.tx_st = glt_pkg::GLT_TX_SEND;
        end
      end
      glt_pkg::GLT_TX_SEND: begin
        if (tx_ready_in && !any_pend) begin
          st_nxt.tx_st = glt_pkg::GLT_TX_IDLE;
        end
      end
      default: begin
        st_nxt.tx_st = glt_pkg::GLT_TX_IDLE;
      end
    endcase
    // load the chosen entry as soon as the link is free
    if (any_pend && (st_r.tx_st != glt_pkg::GLT_TX_SEND || tx_ready_in)) begin
      st_nxt.pend[best] = 1'b0;
      st_nxt.o_tag = st_r.tx_id[best];
      st_nxt.o_lvl = st_r.plvl[best];
      st_nxt.o_stamp = st_r.comp ? st_r.pseq[best] : 16'h0000;
      st_nxt.o_comp = st_r.comp;
      st_nxt.o_last = (st_r.pend & ~(PINS'(1) << best)) == '0;
    end
    // edge detection, set wins over the send-side clear
    for (int i = 0; i < PINS; i++) begin
      if (st_r.s2[i] == st_r.s3[i] && st_r.s3[i] != st_r.stab[i]) begin
        st_nxt.stab[i] = st_r.s3[i];
        if (st_r.tx_en[i]) begin
          if (st_r.echo[i] && st_r.s3[i] == st_r.lvl[i]) begin
            st_nxt.echo[i] = 1'b0;
          end else begin
            // entry will carry this pin's tag
            st_nxt.pend[i] = 1'b1;
            st_nxt.plvl[i] = st_r.s3[i];
            st_nxt.pseq[i] = st_r.now;
          end
        end
      end
    end
    // hold stamped arrivals, drive due ones
    for (int i = 0; i < PINS; i++) begin
      if (drv_en[i]) begin
        st_nxt.hpend[i] = 1'b0;
        st_nxt.lvl[i] = drv_v[i];
        st_nxt.echo[i] = st_r.tx_en[i] && (drv_v[i] != st_r.stab[i]);
      end
      if (rx_valid_in && rx_ready_out && rx_match[i] && rx_comp_in) begin
        st_nxt.hpend[i] = 1'b1;
        st_nxt.hlvl[i] = rx_level_in;
        st_nxt.hts[i] = rx_stamp_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.tx_st <= glt_pkg::GLT_TX_IDLE;
      st_r.dly <= 16'(`GLT_DLY_CYC);
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_out_out[i] = st_r.od[i] ? 1'b0 : st_r.lvl[i];
      pin_oe_out[i] = (st_r.rx_en[i] || st_r.sw_oe[i]) && (!st_r.od[i] || !st_r.lvl[i]);
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign tx_valid_out = st_r.tx_st == glt_pkg::GLT_TX_SEND;
  assign tx_tag_out = st_r.o_tag;
  assign tx_level_out = st_r.o_lvl;
  assign tx_stamp_out = st_r.o_stamp;
  assign tx_comp_out = st_r.o_comp;
  assign tx_last_out = st_r.o_last;
  assign tx_cost_out = st_r.o_comp ? 7'(`GLT_BITS_COMP) : 7'(`GLT_BITS_PLAIN);

  // Checks
  property p_od_low;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st_r.od != '0) |-> (pin_out_out & st_r.od) == '0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin drove high");

  property p_plain_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ce_in && rx_valid_in && rx_ready_out && !rx_comp_in && rx_match != '0)
      |=> (st_r.lvl & $past(rx_match)) == ($past(rx_match) & {PINS{$past(rx_level_in)}});
  endproperty
  a_plain_drive: assert property (p_plain_drive) else $error("plain arrival not driven");

  property p_tx_stable;
    @(posedge sys_clk_in) disable iff (rst_in)
      (tx_valid_out && !tx_ready_in) |=> tx_valid_out && $stable(tx_tag_out) &&
      $stable(tx_level_out);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("send data changed while stalled");

  property p_edge_only;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(st_r.pend[0]) |-> $past(st_r.s2[0] == st_r.s3[0] && st_r.s3[0] != st_r.stab[0]);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("entry without edge");

  property p_read_lat;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ce_in && reg_rd_in && reg_addr_in == `GLT_LEVELS) |=> reg_rdata_out[0] == $past(st_r.stab[0]);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("level read wrong");

  property p_hold_bound;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ce_in && due != '0) |=> (st_r.hpend & $past(due)) == '0;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("held transition overdue");

  property p_no_echo;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ce_in && swallow != '0) |=> (st_r.pend & ~$past(st_r.pend) & $past(swallow)) == '0;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("replayed edge sent back");

  property p_sync_agree;
    @(posedge sys_clk_in) disable iff (rst_in)
      $changed(st_r.stab[0]) |-> $past(st_r.s2[0]) == $past(st_r.s3[0]);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("edge without agreement");

  property p_plain_nostamp;
    @(posedge sys_clk_in) disable iff (rst_in)
      (tx_valid_out && !tx_comp_out) |-> tx_stamp_out == 16'h0000 && tx_cost_out == 7'h28;
  endproperty
  a_plain_nostamp: assert property (p_plain_nostamp) else $error("plain packet has stamp");

endmodule

//--- src/glt_defs.svh
`ifndef GLT_DEFS_SVH
`define GLT_DEFS_SVH

// Register offsets (byte addresses)
`define GLT_CFG_BASE 8'h00
`define GLT_CTRL 8'h40
`define GLT_DELAY 8'h44
`define GLT_LEVELS 8'h48
`define GLT_PENDING 8'h4C

// Per-pin configuration word fields, then the control word's COMP bit
`define GLT_F_TX_EN 0
`define GLT_F_RX_EN 1
`define GLT_F_SW_OE 2
`define GLT_F_OD 3
`define GLT_F_LVL 4
`define GLT_F_PRIO 5
`define GLT_F_IN 6
`define GLT_F_TX_ID 8
`define GLT_F_RX_ID 16
`define GLT_F_COMP 0

// Timing
`define GLT_CLK_NS 10
`define GLT_FWD_COMP_NS 3500
`define GLT_FWD_PLAIN_NS 1000
`define GLT_REV_PLAIN_NS 6000
`define GLT_DLY_CYC ((`GLT_FWD_COMP_NS + `GLT_CLK_NS - 1) / `GLT_CLK_NS)
`define GLT_LAT_CYC (`GLT_REV_PLAIN_NS / `GLT_CLK_NS)

// Link cost per transition, bits
`define GLT_BITS_PLAIN 40
`define GLT_BITS_COMP 80

`endif

//--- src/glt_pkg.sv
package glt_pkg;
  typedef enum logic [1:0] {
    GLT_TX_IDLE = 2'b01,
    GLT_TX_SEND = 2'b10
  } glt_tx_e;
  typedef logic [4:0] glt_tag_t;
  typedef logic [15:0] glt_stamp_t;
endpackage

//--- tb/glt_far_end.sv
`timescale 1ns/1ns
module glt_far_end (
  // Clock, reset, stall
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  // Entries from the device
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire glt_pkg::glt_tag_t tx_tag_in,
  input wire logic tx_level_in,
  input wire glt_pkg::glt_stamp_t tx_stamp_in,
  input wire logic tx_comp_in,
  input wire logic tx_last_in,
  input wire logic [6:0] tx_cost_in,
  // Entries to the device
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output glt_pkg::glt_tag_t rx_tag_out,
  output logic rx_level_out,
  output glt_pkg::glt_stamp_t rx_stamp_out,
  output logic rx_comp_out
);
  logic [30:0] got_q[$];
  logic v_r = 1'b0;
  logic [22:0] f_r = 23'h000000;
  // Idle lines show the inverse, never a stale beat
  assign rx_valid_out = v_r;
  assign {rx_comp_out, rx_level_out, rx_tag_out, rx_stamp_out} = v_r ? f_r : ~f_r;
  always @(posedge sys_clk_in) begin
    tx_ready_out <= !stall_in && !rst_in;
    if (tx_valid_in && tx_ready_out && !rst_in) begin
      got_q.push_back({tx_cost_in, tx_comp_in, tx_last_in, tx_level_in, tx_tag_in, tx_stamp_in});
    end
  end
  task automatic send(input logic [4:0] t, input logic l, input logic [15:0] s, input logic c);
    logic r;
    @(posedge sys_clk_in);
    v_r <= 1'b1;
    f_r <= {c, l, t, s};
    forever begin
      @(negedge sys_clk_in);
      r = rx_ready_in;
      @(posedge sys_clk_in);
      if (r) break;
    end
    v_r <= 1'b0;
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
`include "glt_defs.svh"
module tb;
  logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, stall, ce;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, rd_v;
  logic [12:0] pin_in_in, pin_out_out, pin_oe_out, ext;
  logic tx_valid_out, tx_ready_in, tx_level_out, tx_comp_out, tx_last_out;
  logic rx_valid_in, rx_ready_out, rx_level_in, rx_comp_in;
  glt_pkg::glt_tag_t tx_tag_out, rx_tag_in;
  glt_pkg::glt_tag_t tg [0:6];
  glt_pkg::glt_stamp_t tx_stamp_out, rx_stamp_in, s;
  logic [6:0] tx_cost_out;
  logic [30:0] mdl_q[$];
  int n_errors, tests_run, seed, k;
  int cyc = 0;
  glt_tunnel #(.LAT_MAX(8)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_in_in(pin_in_in),
    .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .tx_tag_out(tx_tag_out), .tx_level_out(tx_level_out),
    .tx_stamp_out(tx_stamp_out), .tx_comp_out(tx_comp_out), .tx_last_out(tx_last_out),
    .tx_cost_out(tx_cost_out), .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
    .rx_tag_in(rx_tag_in), .rx_level_in(rx_level_in), .rx_stamp_in(rx_stamp_in),
    .rx_comp_in(rx_comp_in));
  glt_far_end FAR (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .stall_in(stall),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in), .tx_tag_in(tx_tag_out),
    .tx_level_in(tx_level_out), .tx_stamp_in(tx_stamp_out), .tx_comp_in(tx_comp_out),
    .tx_last_in(tx_last_out), .tx_cost_in(tx_cost_out), .rx_valid_out(rx_valid_in),
    .rx_ready_in(rx_ready_out), .rx_tag_out(rx_tag_in), .rx_level_out(rx_level_in),
    .rx_stamp_out(rx_stamp_in), .rx_comp_out(rx_comp_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Driven pins read back their own level
  always @(posedge sys_clk_in) begin
    pin_in_in <= (pin_oe_out & pin_out_out) | (~pin_oe_out & ext);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    rd_v = reg_rdata_out;
  endtask
  function automatic logic [31:0] cfg(input logic tx, rx, sw, od, lv, pr, input logic [4:0] ti, ri);
    return {11'h000, ri, 3'h0, ti, 2'h0, pr, lv, od, sw, rx, tx};
  endfunction
  function automatic logic [30:0] ent(input logic [4:0] t, input logic l, c, last);
    return {c ? 7'(`GLT_BITS_COMP) : 7'(`GLT_BITS_PLAIN), c, last, l, t, 16'h0000};
  endfunction
  // Stamp is masked: only its presence is modelled
  task automatic take();
    logic [30:0] e;
    k = 0;
    while (FAR.got_q.size() == 0 && k < 40) begin
      @(negedge sys_clk_in);
      k++;
    end
    if (FAR.got_q.size() == 0 || mdl_q.size() == 0) begin
      check("entry count", FAR.got_q.size(), mdl_q.size());
    end else begin
      e = FAR.got_q.pop_front();
      s = e[15:0];
      if (e[23]) e[15:0] = 16'h0000;
      check("link entry", e, mdl_q.pop_front());
    end
  endtask
  initial begin
    {reg_wr_in, reg_rd_in, stall, n_errors, tests_run} = '0;
    {reg_addr_in, reg_wdata_in, ext} = '0;
    ce = 1'b1;
    seed = 22;
    rst_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(`GLT_DELAY);
    check("hold delay", rd_v, 32'h0000015E);
    rd(`GLT_CFG_BASE);
    check("pin cfg", rd_v, 32'h00000000);
    tg[0] = 5'($random(seed));
    for (int i = 1; i < 7; i++) tg[i] = tg[0] + 5'(i);
    wr(8'h00, cfg(1, 0, 0, 0, 0, 0, tg[0], 5'h00));
    wr(8'h04, cfg(0, 1, 0, 0, 0, 0, 5'h00, tg[1]));
    wr(8'h08, cfg(0, 1, 0, 1, 0, 0, 5'h00, tg[1]));
    wr(8'h0C, cfg(1, 1, 0, 0, 0, 0, tg[3], tg[3]));
    wr(8'h10, cfg(0, 0, 1, 0, 1, 0, 5'h00, 5'h00));
    wr(8'h14, cfg(1, 0, 0, 0, 0, 0, tg[5], 5'h00));
    wr(8'h18, cfg(1, 0, 0, 0, 0, 1, tg[6], 5'h00));
    wr(8'h34, 32'hFFFFFFFF);
    rd(8'h34);
    check("pin 13 cfg", rd_v, 32'h00000000);
    rd(8'h50);
    check("unmapped", rd_v, 32'h00000000);
    rd(8'h10);
    check("sw pin cfg", rd_v & 32'hFFFFFFBF, cfg(0, 0, 1, 0, 1, 0, 5'h00, 5'h00));
    repeat (5) @(negedge sys_clk_in);
    check("sw drive", {pin_oe_out[4], pin_out_out[4], pin_oe_out[0]}, 3'b110);
    // slow toggles, far end stalls first
    @(posedge sys_clk_in);
    stall <= 1'b1;
    ext[0] <= 1'b1;
    mdl_q.push_back(ent(tg[0], 1, 0, 1));
    repeat (12) @(negedge sys_clk_in);
    check("held valid", tx_valid_out, 1'b1);
    @(posedge sys_clk_in);
    stall <= 1'b0;
    take();
    rd(`GLT_LEVELS);
    check("levels", rd_v[0], 1'b1);
    @(posedge sys_clk_in);
    ext[6:5] <= 2'b11;
    mdl_q.push_back(ent(tg[6], 1, 0, 0));
    mdl_q.push_back(ent(tg[5], 1, 0, 1));
    take();
    take();
    // Aged entry overtakes the prioritised pin
    @(posedge sys_clk_in);
    stall <= 1'b1;
    ext[0] <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    ext[5] <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    ext[6] <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    stall <= 1'b0;
    mdl_q.push_back(ent(tg[0], 0, 0, 1));
    mdl_q.push_back(ent(tg[5], 0, 0, 0));
    mdl_q.push_back(ent(tg[6], 0, 0, 1));
    take();
    take();
    take();
    FAR.send(tg[1], 1'b1, 16'h0000, 1'b0);
    @(negedge sys_clk_in);
    check("pin1 drive", {pin_oe_out[1], pin_out_out[1]}, 2'b11);
    check("od high", {pin_oe_out[2], pin_out_out[2]}, 2'b00);
    FAR.send(tg[2], 1'b0, 16'h0000, 1'b0);
    repeat (2) @(negedge sys_clk_in);
    check("foreign tag", pin_out_out[1], 1'b1);
    FAR.send(tg[3], 1'b1, 16'h0000, 1'b0);
    repeat (20) @(negedge sys_clk_in);
    check("pin3 drive", pin_out_out[3], 1'b1);
    check("echo entries", FAR.got_q.size(), 0);
    wr(`GLT_DELAY, 32'h00000028);
    wr(`GLT_CTRL, 32'h00000001);
    @(posedge sys_clk_in);
    ext[0] <= 1'b1;
    mdl_q.push_back(ent(tg[0], 1, 1, 1));
    take();
    FAR.send(tg[1], 1'b0, s, 1'b1);
    repeat (20) @(negedge sys_clk_in);
    check("held pin", pin_out_out[1], 1'b1);
    // Same tag again must wait for the release
    FAR.send(tg[1], 1'b0, s, 1'b1);
    @(negedge sys_clk_in);
    check("refused beat", {pin_out_out[1], rx_ready_out}, 2'b01);
    k = 0;
    while (pin_out_out[1] !== 1'b0 && k < 40) begin
      @(negedge sys_clk_in);
      k++;
    end
    check("late pin", pin_out_out[1], 1'b0);
    check("od low", {pin_oe_out[2], pin_out_out[2]}, 2'b10);
    // Frozen block sees no edge until enabled
    @(posedge sys_clk_in);
    ce <= 1'b0;
    ext[0] <= 1'b0;
    repeat (20) @(negedge sys_clk_in);
    check("frozen entries", {tx_valid_out, FAR.got_q.size() != 0}, 2'b00);
    @(posedge sys_clk_in);
    ce <= 1'b1;
    mdl_q.push_back(ent(tg[0], 0, 1, 1));
    take();
    repeat (100) @(negedge sys_clk_in);
    check("idle entries", FAR.got_q.size(), 0);
    report_and_stop();
  end
endmodule
